// ===== rtl/isi_pkg.sv
package isi_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BIT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] BIT_LAST = 4'h7;
  localparam logic [CNT_W-1:0] BIT_FULL = 4'h8;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam int MSB_POS = 7;
  localparam int RW_POS = 0;
  // Program location the bus interrupt vectors to in the host core
  localparam logic [7:0] IRQ_VECTOR = 8'h10;

  typedef struct packed {
    logic busEnableBit;
    logic transmitModeBit;
    logic ackOutBit;
  } isi_ctrl_type;

  localparam isi_ctrl_type CTRL_RST = 3'h0;

  typedef struct packed {
    logic byteCompleteFlag;
    logic addressMatchedFlag;
    logic busBusyFlag;
    logic readWriteFlag;
    logic ackInFlag;
  } isi_status_type;

  localparam isi_status_type STATUS_RST = 5'h00;

  typedef struct packed {
    logic scl;
    logic sda;
  } isi_pins_type;

  localparam isi_pins_type PINS_IDLE = 2'h3;

  typedef struct packed {
    isi_ctrl_type ctrl;
    logic [ADDR_W-1:0] ownAddress;
  } isi_cfg_type;

  localparam isi_cfg_type CFG_RST = 10'h000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_HOLD,
    ST_TX,
    ST_TX_ACK,
    ST_RX,
    ST_RX_ACK
  } isi_state_type;
endpackage

// ===== rtl/isi_slave.sv
// Overview of operation
// - SDA falling while SCL high sets busy
// - STOP condition clears the busy flag
// - Compare first seven bits with own address
// - Match raises interrupt, latches eighth bit
// - Match drives low acknowledge in ninth bit
// - Match sets address-matched status flag
// - Control write clears address-matched flag
// - Hold SCL low until data register serviced
// - Read/write one means transmit, zero receive
// - Direction follows transmit-mode control bit
// - Bytes are eight bits, MSB first
// - Receiver acknowledges with ack-out bit, keeps accepting bytes
// - Transmitter releases SDA on no acknowledge
// - All data bytes pass through one data register
// - Receiver drives ack-out bit in ninth clock
// - Transmitter captures master acknowledge into flag
// - Byte-complete clears during transfer, sets after
// - Interrupt vectors to location 10H
module isi_slave (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic clk_link,
  input wire logic ctrlWrite,
  input wire isi_pkg::isi_ctrl_type ctrlIn,
  input wire logic [isi_pkg::ADDR_W-1:0] ownAddressRegister,
  input wire logic dataWrite,
  input wire logic [isi_pkg::DATA_W-1:0] dataIn,
  input wire logic dataRead,
  output isi_pkg::isi_ctrl_type ctrlReg,
  output logic [isi_pkg::DATA_W-1:0] busDataRegister,
  output isi_pkg::isi_status_type status,
  output logic busIrq,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  // System domain: control, data register, status
  logic relTog;
  logic [1:0] evtMeta;
  logic [1:0] evtSync;
  logic [1:0] evtSeen;
  logic busyMeta;
  logic busySync;
  logic matchEvt;
  logic doneEvt;

  // Link domain
  logic rstMeta;
  logic linkRst;
  isi_pkg::isi_cfg_type cfgMeta;
  isi_pkg::isi_cfg_type cfgSync;
  isi_pkg::isi_pins_type pinMeta;
  isi_pkg::isi_pins_type pinSync;
  isi_pkg::isi_pins_type pinPrev;
  logic relMeta;
  logic relSync;
  logic relSeen;
  logic relEvt;
  isi_pkg::isi_state_type state;
  logic [isi_pkg::CNT_W-1:0] bitCnt;
  logic [isi_pkg::DATA_W-1:0] shReg;
  logic [isi_pkg::DATA_W-1:0] rxByte;
  logic linkBusy;
  logic rwLink;
  logic ackLink;
  logic matchTog;
  logic doneTog;
  logic startSeen;
  logic stopSeen;
  logic sclRise;
  logic sclFall;
  logic addrHit;

  assign matchEvt = evtSync[0] ^ evtSeen[0];
  assign doneEvt = evtSync[1] ^ evtSeen[1];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrlReg <= isi_pkg::CTRL_RST;
    end else if (ctrlWrite) begin
      ctrlReg <= ctrlIn;
    end
  end
  // Any data register access, write or dummy read, lets the link go on
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      relTog <= 1'b0;
    end else if (dataWrite || dataRead) begin
      relTog <= ~relTog;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busDataRegister <= isi_pkg::DATA_RST;
    end else if (dataWrite) begin
      busDataRegister <= dataIn;
    end else if (doneEvt && !ctrlReg.transmitModeBit) begin
      busDataRegister <= rxByte;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      evtMeta <= 2'h0;
      evtSync <= 2'h0;
      evtSeen <= 2'h0;
      busyMeta <= 1'b0;
      busySync <= 1'b0;
    end else begin
      evtMeta <= {doneTog, matchTog};
      evtSync <= evtMeta;
      evtSeen <= evtSync;
      busyMeta <= linkBusy;
      busySync <= busyMeta;
    end
  end

  // Set beats clear on the matched and byte-complete flags so a late event is never lost
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      status <= isi_pkg::STATUS_RST;
    end else begin
      status.busBusyFlag <= busySync;
      if (matchEvt) begin
        status.addressMatchedFlag <= 1'b1;
        status.readWriteFlag <= rwLink;
      end else if (ctrlWrite) begin
        status.addressMatchedFlag <= 1'b0;
      end
      if (doneEvt) begin
        status.byteCompleteFlag <= 1'b1;
      end else if (dataWrite || dataRead || matchEvt) begin
        status.byteCompleteFlag <= 1'b0;
      end
      if (doneEvt && ctrlReg.transmitModeBit) begin
        status.ackInFlag <= ackLink;
      end
    end
  end

  // One-cycle request; the core vectors it to isi_pkg::IRQ_VECTOR
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      busIrq <= 1'b0;
    end else begin
      busIrq <= matchEvt || doneEvt;
    end
  end

  // Link domain reset and configuration crossings
  always_ff @(posedge clk_link) begin
    rstMeta <= sys_rst;
    linkRst <= rstMeta;
  end

  // Configuration is quasi-static, so a plain two-flop per bit suffices
  always_ff @(posedge clk_link) begin
    if (linkRst) begin
      cfgMeta <= isi_pkg::CFG_RST;
      cfgSync <= isi_pkg::CFG_RST;
      relMeta <= 1'b0;
      relSync <= 1'b0;
      relSeen <= 1'b0;
    end else begin
      cfgMeta <= {ctrlReg, ownAddressRegister};
      cfgSync <= cfgMeta;
      relMeta <= relTog;
      relSync <= relMeta;
      relSeen <= relSync;
    end
  end

  assign relEvt = relSync ^ relSeen;
  always_ff @(posedge clk_link) begin
    if (linkRst) begin
      pinMeta <= isi_pkg::PINS_IDLE;
      pinSync <= isi_pkg::PINS_IDLE;
      pinPrev <= isi_pkg::PINS_IDLE;
    end else begin
      pinMeta <= {sclIn, sdaIn};
      pinSync <= pinMeta;
      pinPrev <= pinSync;
    end
  end

  // Data edges are only taken with SCL stable, so START/STOP stay distinct
  assign startSeen = pinSync.scl && pinPrev.scl && pinPrev.sda && !pinSync.sda;
  assign stopSeen = pinSync.scl && pinPrev.scl && !pinPrev.sda && pinSync.sda;
  assign sclRise = pinSync.scl && !pinPrev.scl;
  assign sclFall = !pinSync.scl && pinPrev.scl;
  assign addrHit = shReg[isi_pkg::DATA_W-1:1] == cfgSync.ownAddress;

  always_ff @(posedge clk_link) begin
    if (linkRst || !cfgSync.ctrl.busEnableBit) begin
      linkBusy <= 1'b0;
    end else if (startSeen) begin
      linkBusy <= 1'b1;
    end else if (stopSeen) begin
      linkBusy <= 1'b0;
    end
  end
  always_ff @(posedge clk_link) begin
    if (linkRst) begin
      ackLink <= 1'b0;
    end else if (state == isi_pkg::ST_TX_ACK && sclRise) begin
      ackLink <= pinSync.sda;
    end
  end
  always_ff @(posedge clk_link) begin
    if (linkRst || !cfgSync.ctrl.busEnableBit) begin
      state <= isi_pkg::ST_IDLE;
      bitCnt <= isi_pkg::BIT_ZERO;
      shReg <= isi_pkg::DATA_RST;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
      if (linkRst) begin
        rxByte <= isi_pkg::DATA_RST;
        rwLink <= 1'b0;
        matchTog <= 1'b0;
        doneTog <= 1'b0;
      end
    end else if (startSeen) begin
      state <= isi_pkg::ST_ADDR;
      bitCnt <= isi_pkg::BIT_ZERO;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end else if (stopSeen) begin
      state <= isi_pkg::ST_IDLE;
      sdaOe <= 1'b0;
      sclOe <= 1'b0;
    end else begin
      unique case (state)
        isi_pkg::ST_IDLE: begin
          sdaOe <= 1'b0;
        end
        isi_pkg::ST_ADDR: begin
          if (sclRise) begin
            shReg <= {shReg[isi_pkg::DATA_W-2:0], pinSync.sda};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == isi_pkg::BIT_FULL) begin
            bitCnt <= isi_pkg::BIT_ZERO;
            if (addrHit) begin
              sdaOe <= 1'b1;
              rwLink <= shReg[isi_pkg::RW_POS];
              matchTog <= ~matchTog;
              state <= isi_pkg::ST_ADDR_ACK;
            end else begin
              // Not ours: sit out until the master ends the frame
              state <= isi_pkg::ST_IDLE;
            end
          end
        end
        isi_pkg::ST_ADDR_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            sclOe <= 1'b1;
            state <= isi_pkg::ST_HOLD;
          end
        end
        isi_pkg::ST_HOLD: begin
          // Next data bit is set up while SCL is still held low
          if (relEvt) begin
            bitCnt <= isi_pkg::BIT_ZERO;
            if (cfgSync.ctrl.transmitModeBit) begin
              shReg <= busDataRegister;
              sdaOe <= !busDataRegister[isi_pkg::MSB_POS];
              state <= isi_pkg::ST_TX;
            end else begin
              sdaOe <= 1'b0;
              state <= isi_pkg::ST_RX;
            end
          end
        end
        isi_pkg::ST_TX: begin
          sclOe <= 1'b0;
          if (sclFall) begin
            if (bitCnt == isi_pkg::BIT_LAST) begin
              sdaOe <= 1'b0;
              state <= isi_pkg::ST_TX_ACK;
            end else begin
              bitCnt <= bitCnt + 4'h1;
              shReg <= {shReg[isi_pkg::DATA_W-2:0], 1'b0};
              sdaOe <= !shReg[isi_pkg::MSB_POS-1];
            end
          end
        end
        isi_pkg::ST_TX_ACK: begin
          // SDA stays released; software picks the next step from ack-in
          if (sclFall) begin
            doneTog <= ~doneTog;
            sclOe <= 1'b1;
            state <= isi_pkg::ST_HOLD;
          end
        end
        isi_pkg::ST_RX: begin
          sclOe <= 1'b0;
          if (sclRise) begin
            shReg <= {shReg[isi_pkg::DATA_W-2:0], pinSync.sda};
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == isi_pkg::BIT_FULL) begin
            rxByte <= shReg;
            sdaOe <= !cfgSync.ctrl.ackOutBit;
            state <= isi_pkg::ST_RX_ACK;
          end
        end
        isi_pkg::ST_RX_ACK: begin
          if (sclFall) begin
            sdaOe <= 1'b0;
            doneTog <= ~doneTog;
            sclOe <= 1'b1;
            state <= isi_pkg::ST_HOLD;
          end
        end
      endcase
    end
  end

  // Open-drain lines only ever pull low
  always_ff @(posedge clk_link) begin
    sdaOut <= 1'b0;
    sclOut <= 1'b0;
  end

  a_start_sets_busy: assert property (@(posedge clk_link) disable iff (linkRst)
    (startSeen && cfgSync.ctrl.busEnableBit) |=> linkBusy)
    else $error("Busy not set after start");
  a_stop_clears_busy: assert property (@(posedge clk_link) disable iff (linkRst)
    (stopSeen && !startSeen) |=> !linkBusy)
    else $error("Busy not cleared after stop");
  a_match_drives_ack: assert property (@(posedge clk_link) disable iff (linkRst)
    (cfgSync.ctrl.busEnableBit && !startSeen && !stopSeen && state == isi_pkg::ST_ADDR && sclFall
     && bitCnt == isi_pkg::BIT_FULL && addrHit) |=> (sdaOe && state == isi_pkg::ST_ADDR_ACK))
    else $error("No acknowledge on address match");
  a_match_latches_rw: assert property (@(posedge clk_link) disable iff (linkRst)
    $changed(matchTog) |-> rwLink == $past(shReg[isi_pkg::RW_POS]))
    else $error("Direction bit not latched");
  a_miss_no_ack: assert property (@(posedge clk_link) disable iff (linkRst)
    (state == isi_pkg::ST_ADDR && sclFall && bitCnt == isi_pkg::BIT_FULL && !addrHit) |=> !sdaOe)
    else $error("Acknowledge on foreign address");
  a_hold_stretches: assert property (@(posedge clk_link) disable iff (linkRst)
    (state == isi_pkg::ST_HOLD && !relEvt && !startSeen && !stopSeen && cfgSync.ctrl.busEnableBit)
    |=> sclOe)
    else $error("SCL released before service");
  a_rx_ack_value: assert property (@(posedge clk_link) disable iff (linkRst)
    (state == isi_pkg::ST_RX_ACK) |-> sdaOe == !cfgSync.ctrl.ackOutBit)
    else $error("Receive acknowledge differs from ack-out bit");
  a_disabled_release: assert property (@(posedge clk_link) disable iff (linkRst)
    !cfgSync.ctrl.busEnableBit |=> (!sdaOe && !sclOe && !linkBusy))
    else $error("Lines driven while disabled");
  a_ctrl_clears_match: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (ctrlWrite && !matchEvt) |=> !status.addressMatchedFlag)
    else $error("Matched flag survived control write");
  a_done_sets_flag: assert property (@(posedge clk_sys) disable iff (sys_rst)
    doneEvt |=> (status.byteCompleteFlag && busIrq))
    else $error("Byte complete not flagged");

endmodule

// ===== dv/isi_master.sv
module isi_master (
  input wire logic clkLink,
  input wire logic scl,
  input wire logic sda,
  output logic sclOe,
  output logic sdaOe
);
  timeunit 1ns;
  timeprecision 100ps;
  int stallCount = 0;
  initial begin
    sclOe = 1'b0;
    sdaOe = 1'b0;
  end
  task automatic pause();
    repeat (5) @(posedge clkLink);
    #2;
  endtask
  // Bounded, so a slave that never lets go shows as a stall, not a hang
  task automatic sclHigh();
    int n;
    n = 0;
    sclOe = 1'b0;
    while (scl !== 1'b1 && n < 9000) begin
      @(posedge clkLink);
      n++;
    end
    #2;
    if (n == 9000) stallCount++;
    pause();
  endtask
  task automatic bitOut(input logic b);
    sdaOe = ~b;
    pause();
    sclHigh();
    sclOe = 1'b1;
    pause();
  endtask
  task automatic bitIn(output logic b);
    sdaOe = 1'b0;
    pause();
    sclHigh();
    b = sda;
    sclOe = 1'b1;
    pause();
  endtask
  task automatic start();
    sdaOe = 1'b0;
    pause();
    sclHigh();
    sdaOe = 1'b1;
    pause();
    sclOe = 1'b1;
    pause();
  endtask
  task automatic stop();
    sdaOe = 1'b1;
    pause();
    sclHigh();
    sdaOe = 1'b0;
    pause();
  endtask
  task automatic sendByte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitOut(v[i]);
    end
    bitIn(ack);
  endtask
  task automatic getByte(input logic nack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      bitIn(v[i]);
    end
    bitOut(nack);
  endtask
endmodule

// ===== dv/isi_slave_bench.sv
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin nFail++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module isi_slave_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic clkLink = 1'b0;
  logic sys_rst = 1'b1;
  logic ctrlWrite = 1'b0;
  logic dataWrite = 1'b0;
  logic dataRead = 1'b0;
  isi_pkg::isi_ctrl_type ctrlIn = isi_pkg::CTRL_RST;
  logic [6:0] own = isi_pkg::ADDR_RST;
  logic [7:0] dataIn = isi_pkg::DATA_RST;
  isi_pkg::isi_ctrl_type ctrlReg;
  isi_pkg::isi_status_type st;
  logic [7:0] busData;
  logic busIrq, sclOut, sclOe, sdaOut, sdaOe, mSclOe, mSdaOe, scl, sda;
  logic [31:0] seed = 32'hf344;
  int nFail = 0;
  int cmpCount = 0;
  int irqCount = 0;
  int expIrq = 0;
  logic [7:0] dataQ[$];
  always #20 clk_sys = ~clk_sys;
  always #62.5 clkLink = ~clkLink;
  // Pull-ups: a line is low while either side pulls it
  assign scl = ~(mSclOe | (sclOe & ~sclOut));
  assign sda = ~(mSdaOe | (sdaOe & ~sdaOut));
  always @(posedge clk_sys) irqCount <= irqCount + int'(busIrq === 1'b1);
  isi_slave i_isi_slave (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_link(clkLink),
    .ctrlWrite(ctrlWrite), .ctrlIn(ctrlIn), .ownAddressRegister(own),
    .dataWrite(dataWrite), .dataIn(dataIn), .dataRead(dataRead),
    .ctrlReg(ctrlReg), .busDataRegister(busData), .status(st), .busIrq(busIrq),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe)
  );
  isi_master i_isi_master (
    .clkLink(clkLink), .scl(scl), .sda(sda), .sclOe(mSclOe), .sdaOe(mSdaOe)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic sysWait(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  // The tail wait lets each write cross to the link side
  task automatic ctrl(input logic [2:0] c);
    sysWait(1);
    ctrlIn = c;
    ctrlWrite = 1'b1;
    sysWait(1);
    ctrlWrite = 1'b0;
    sysWait(20);
  endtask
  task automatic access(input logic wr, input logic [7:0] v);
    sysWait(1);
    dataIn = v;
    dataWrite = wr;
    dataRead = ~wr;
    sysWait(1);
    dataWrite = 1'b0;
    dataRead = 1'b0;
    sysWait(20);
  endtask
  task automatic finishTest();
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    nFail++;
    $display("watchdog expired");
    finishTest();
  end
  initial begin
    logic ack;
    logic [7:0] v;
    logic [7:0] b;
    own = 7'(rnd());
    repeat (5) @(posedge clkLink);
    #1;
    `CHK("status", isi_pkg::STATUS_RST, st)
    `CHK("ctrl", isi_pkg::CTRL_RST, ctrlReg)
    `CHK("lines", 2'h0, {sclOe, sdaOe})
    `CHK("vector", 8'h10, isi_pkg::IRQ_VECTOR)
    sysWait(1);
    sys_rst = 1'b0;
    repeat (4) @(posedge clkLink);
    $display("test reset done");
    i_isi_master.start();
    i_isi_master.sendByte({own, 1'b0}, ack);
    `CHK("ack", 1'b1, ack)
    `CHK("busy", 1'b0, st.busBusyFlag)
    i_isi_master.stop();
    $display("test disabled done");
    ctrl(3'h4);
    i_isi_master.start();
    `CHK("busy", 1'b1, st.busBusyFlag)
    i_isi_master.sendByte({own ^ 7'h40, 1'b0}, ack);
    `CHK("ack", 1'b1, ack)
    `CHK("irq", expIrq, irqCount)
    i_isi_master.stop();
    `CHK("busy", 1'b0, st.busBusyFlag)
    $display("test foreign done");
    i_isi_master.start();
    i_isi_master.sendByte({own, 1'b0}, ack);
    expIrq++;
    `CHK("ack", 1'b0, ack)
    `CHK("irq", expIrq, irqCount)
    `CHK("match", 1'b1, st.addressMatchedFlag)
    `CHK("rw", 1'b0, st.readWriteFlag)
    `CHK("stretch", 1'b1, sclOe)
    ctrl(3'h4);
    `CHK("match", 1'b0, st.addressMatchedFlag)
    access(1'b0, 8'h00);
    `CHK("stretch", 1'b0, sclOe)
    for (int i = 0; i < 2; i++) begin
      dataQ.push_back(8'(rnd()));
      i_isi_master.sendByte(dataQ[0], ack);
      expIrq++;
      b = dataQ.pop_front();
      `CHK("ack", i[0], ack)
      `CHK("irq", expIrq, irqCount)
      `CHK("done", 1'b1, st.byteCompleteFlag)
      `CHK("data", b, busData)
      ctrl(3'h5);
      access(1'b0, 8'h00);
      `CHK("done", 1'b0, st.byteCompleteFlag)
    end
    i_isi_master.stop();
    $display("test write done");
    i_isi_master.start();
    i_isi_master.sendByte({own, 1'b1}, ack);
    expIrq++;
    `CHK("ack", 1'b0, ack)
    `CHK("rw", 1'b1, st.readWriteFlag)
    ctrl(3'h6);
    `CHK("ctrl", 3'h6, ctrlReg)
    for (int i = 0; i < 2; i++) begin
      dataQ.push_back(8'(rnd()));
      access(1'b1, dataQ[0]);
      i_isi_master.getByte(i[0], v);
      expIrq++;
      b = dataQ.pop_front();
      `CHK("rxbyte", b, v)
      `CHK("irq", expIrq, irqCount)
      `CHK("ackin", i[0], st.ackInFlag)
    end
    ctrl(3'h4);
    access(1'b0, 8'h00);
    `CHK("sda", 1'b0, sdaOe)
    `CHK("stretch", 1'b0, sclOe)
    i_isi_master.stop();
    `CHK("busy", 1'b0, st.busBusyFlag)
    `CHK("stall", 0, i_isi_master.stallCount)
    $display("test read done");
    finishTest();
  end
endmodule
